// ### logic/rsq_pkg.sv
// package: constants and carrier types for the reset sequencer
package rsq_pkg;
  localparam int CNT_W = 12;
  // stabilization and release delays in reference clock cycles
  localparam int STAB_CYC = 4096;
  localparam int PIN_REL_CYC = 32;
  localparam int CPU_REL_CYC = 64;
  localparam int SHORT_REC_CYC = 32;
  localparam int WDOG_W = 8;
  localparam logic [15:0] WDOG_CLR_ADDR = 16'hffff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // status register layout, offsets on the register port
  localparam logic [15:0] STATUS_ADDR = 16'hfe01;
  localparam logic [15:0] CONFIG_ADDR = 16'hfe02;
  localparam int ST_POR = 7;
  localparam int ST_PIN = 6;
  localparam int ST_WDOG = 5;
  localparam int ST_BADOP = 4;
  localparam int ST_MON = 3;
  localparam int ST_LV = 1;
  localparam int CFG_SHORT = 0;
  localparam logic [7:0] STATUS_POR_VAL = 8'h82;
  localparam logic [7:0] CONFIG_RST = 8'h00;

  typedef enum logic [1:0] {RSQ_SRC_NONE, RSQ_SRC_LV, RSQ_SRC_INT, RSQ_SRC_PIN} rsq_src_t;

  typedef struct packed {
    logic bad_opcode;
    logic monitor_entry;
    logic stop_exec;
    logic wakeup;
  } rsq_cpu_ev_t;
endpackage : rsq_pkg

// ### logic/rsq_reset_sequencer.sv
// reset sequencer with stabilization counter, watchdog and reset status
//
// Contract
// - power-on reset stops cpu and module clocks for 4096 reference cycles
// - power-on reset drives reset pin low during stabilization delay
// - power-on or low-voltage reset releases pin 32 cycles after stabilization
// - power-on or low-voltage reset releases cpu 64 cycles after stabilization
// - power-on sets power-on and low-voltage flags, clears others
// - watchdog overflow causes internal reset and sets watchdog flag
// - any write to address ffff clears watchdog counter
// - low-voltage holds pin low while supply low, then 4096 cycle delay
// - low-voltage reset sets low-voltage flag
// - illegal opcode causes internal reset and sets its flag
// - monitor entry with erased reset vector causes internal reset
// - every internal reset source pulls reset pin low
// - internal reset holds pin 4096+32 cycles, cpu released 32 later
// - stabilization counter is 12 bits wide
// - stabilization counter prescales the watchdog counter
// - stop instruction clears the stabilization counter
// - stop wakeup delay is 32 with short recovery, else 4096
// - external pin reset leaves stabilization counter unaffected
// - stabilization counter runs freely after every reset
// - power-on pulse, then clock generator enabled after initialization
//
// Design decisions made here: the plain strobed port and the register addresses.
module rsq_reset_sequencer (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_low_voltage,
  input wire logic i_rst_pin_in,
  input wire rsq_pkg::rsq_cpu_ev_t i_cpu_ev,
  input wire logic [7:0] i_vector_byte,
  input wire logic [rsq_pkg::ADDR_W-1:0] i_addr,
  input wire logic [rsq_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [rsq_pkg::DATA_W-1:0] o_rdata,
  output logic o_rst_pin_out,
  output logic o_rst_pin_oe_n,
  output logic o_cpu_rst_n,
  output logic o_clk_run,
  output logic o_clk_gen_en,
  output logic o_poweron_pulse
);
  localparam int PIN_END = rsq_pkg::STAB_CYC + rsq_pkg::PIN_REL_CYC;
  localparam int CPU_END = rsq_pkg::STAB_CYC + rsq_pkg::CPU_REL_CYC;
  localparam int SEQ_W = 13;

  typedef enum logic [2:0] {ST_LVHOLD, ST_STAB, ST_PINHOLD, ST_CPUHOLD, ST_RUN, ST_STOP, ST_WAKE} rsq_state_t;

  rsq_state_t state_r;
  logic [SEQ_W-1:0] seq_r;
  logic [rsq_pkg::CNT_W-1:0] cnt_r;
  logic [rsq_pkg::WDOG_W-1:0] wdog_r;
  logic [7:0] status_r;
  logic [7:0] config_r;
  logic lv_s1_r, lv_s2_r, pin_s1_r, pin_s2_r, pin_d_r;
  logic por_seen_r;
  logic wdog_ovf, int_req, pin_fall, wdog_clr;
  logic [SEQ_W-1:0] wake_len;

  // synchronisers for pin-level inputs
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      lv_s1_r <= 1'b0;
      lv_s2_r <= 1'b0;
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      pin_d_r <= 1'b1;
    end
    else
    begin
      lv_s1_r <= i_low_voltage;
      lv_s2_r <= lv_s1_r;
      pin_s1_r <= i_rst_pin_in;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  assign wdog_clr = i_wr && (i_addr == rsq_pkg::WDOG_CLR_ADDR);
  assign wdog_ovf = (state_r == ST_RUN) && (&wdog_r) && (&cnt_r) && !wdog_clr;
  assign pin_fall = pin_d_r && !pin_s2_r && o_rst_pin_oe_n;
  // merged internal request
  assign int_req = (state_r == ST_RUN) && (wdog_ovf || i_cpu_ev.bad_opcode ||
    (i_cpu_ev.monitor_entry && i_vector_byte == rsq_pkg::ERASED_BYTE));
  assign wake_len = config_r[rsq_pkg::CFG_SHORT] ? SEQ_W'(rsq_pkg::SHORT_REC_CYC) :
    SEQ_W'(rsq_pkg::STAB_CYC);

  // sequence state and its cycle counter
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r <= ST_LVHOLD;
      seq_r <= '0;
    end
    else if (lv_s2_r)
    begin
      state_r <= ST_LVHOLD;
      seq_r <= '0;
    end
    else if (int_req)
    begin
      state_r <= ST_STAB;
      seq_r <= '0;
    end
    else if (pin_fall && state_r == ST_RUN)
    begin
      state_r <= ST_CPUHOLD;
      seq_r <= SEQ_W'(PIN_END);
    end
    else
    begin
      case (state_r)
        ST_LVHOLD:
        begin
          state_r <= ST_STAB;
          seq_r <= '0;
        end
        ST_STAB:
        begin
          seq_r <= seq_r + 1'b1;
          if (seq_r == SEQ_W'(rsq_pkg::STAB_CYC - 1))
            state_r <= ST_PINHOLD;
        end
        ST_PINHOLD:
        begin
          seq_r <= seq_r + 1'b1;
          if (seq_r == SEQ_W'(PIN_END - 1))
            state_r <= ST_CPUHOLD;
        end
        ST_CPUHOLD:
        begin
          seq_r <= seq_r + 1'b1;
          if (seq_r == SEQ_W'(CPU_END - 1))
            state_r <= ST_RUN;
        end
        ST_RUN:
        begin
          seq_r <= '0;
          if (i_cpu_ev.stop_exec)
            state_r <= ST_STOP;
        end
        ST_STOP:
        begin
          seq_r <= '0;
          if (i_cpu_ev.wakeup)
            state_r <= ST_WAKE;
        end
        ST_WAKE:
        begin
          seq_r <= seq_r + 1'b1;
          if (seq_r == wake_len - 1'b1)
            state_r <= ST_RUN;
        end
        default:
        begin
          state_r <= ST_LVHOLD;
          seq_r <= '0;
        end
      endcase
    end
  end

  // free-running stabilization counter
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt_r <= '0;
    else if (state_r == ST_RUN && i_cpu_ev.stop_exec)
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + 1'b1;
  end

  // watchdog counter prescaled by stabilization counter wrap
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      wdog_r <= '0;
    else if (wdog_clr || state_r != ST_RUN)
      wdog_r <= '0;
    else if (&cnt_r)
      wdog_r <= wdog_r + 1'b1;
  end

  // reset status flags
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      status_r <= rsq_pkg::STATUS_POR_VAL;
      por_seen_r <= 1'b0;
    end
    else
    begin
      por_seen_r <= 1'b1;
      if (lv_s2_r && por_seen_r)
        status_r <= 8'h01 << rsq_pkg::ST_LV;
      else if (int_req)
      begin
        status_r <= '0;
        status_r[rsq_pkg::ST_WDOG] <= wdog_ovf;
        status_r[rsq_pkg::ST_BADOP] <= i_cpu_ev.bad_opcode;
        status_r[rsq_pkg::ST_MON] <= !wdog_ovf && !i_cpu_ev.bad_opcode;
      end
      else if (pin_fall && state_r == ST_RUN)
        status_r <= 8'h01 << rsq_pkg::ST_PIN;
    end
  end

  // configuration register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      config_r <= rsq_pkg::CONFIG_RST;
    else if (i_wr && i_addr == rsq_pkg::CONFIG_ADDR)
      config_r <= i_wdata;
  end

  // read port, data one cycle after strobe
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_rdata <= '0;
    else if (i_rd && i_addr == rsq_pkg::STATUS_ADDR)
      o_rdata <= status_r;
    else if (i_rd && i_addr == rsq_pkg::CONFIG_ADDR)
      o_rdata <= config_r;
    else
      o_rdata <= '0;
  end

  // outputs from flip-flops, decoded from the current state, so they lag it by one cycle
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rst_pin_out <= 1'b0;
      o_rst_pin_oe_n <= 1'b0;
      o_cpu_rst_n <= 1'b0;
      o_clk_run <= 1'b0;
      o_clk_gen_en <= 1'b0;
      o_poweron_pulse <= 1'b1;
    end
    else
    begin
      o_rst_pin_out <= 1'b0;
      o_rst_pin_oe_n <= !(state_r == ST_LVHOLD || state_r == ST_STAB || state_r == ST_PINHOLD);
      o_cpu_rst_n <= (state_r == ST_RUN || state_r == ST_STOP || state_r == ST_WAKE);
      o_clk_run <= !(state_r == ST_LVHOLD || state_r == ST_STAB || state_r == ST_STOP || state_r == ST_WAKE);
      o_clk_gen_en <= (state_r != ST_LVHOLD);
      o_poweron_pulse <= 1'b0;
    end
  end

  // assertions
  sequence s_stab_end;
    state_r == ST_STAB && seq_r == SEQ_W'(rsq_pkg::STAB_CYC - 1);
  endsequence
  sequence s_pin_release;
    !o_rst_pin_oe_n [*8] ##26 o_rst_pin_oe_n;
  endsequence

  property p_pin_release;
    @(posedge i_clk) disable iff (!i_rst_n)
    (s_stab_end and (!lv_s2_r && !int_req)) ##1 1'b1 |-> s_pin_release;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("pin not released 32 cycles after delay");

  property p_cpu_release;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_r == ST_CPUHOLD && seq_r == SEQ_W'(CPU_END - 1) && !lv_s2_r && !int_req && !pin_fall)
      |=> ##1 o_cpu_rst_n && $rose(o_cpu_rst_n);
  endproperty
  a_cpu_release: assert property (p_cpu_release) else $error("cpu not released at 64 cycles");

  property p_stab_clk;
    @(posedge i_clk) disable iff (!i_rst_n)
    state_r == ST_STAB |=> !o_clk_run;
  endproperty
  a_stab_clk: assert property (p_stab_clk) else $error("clocks run during stabilization");

  property p_stab_pin;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_r == ST_STAB || state_r == ST_LVHOLD) |=> !o_rst_pin_oe_n && !o_rst_pin_out;
  endproperty
  a_stab_pin: assert property (p_stab_pin) else $error("pin not driven low in reset");

  property p_wdog_flag;
    @(posedge i_clk) disable iff (!i_rst_n)
    wdog_ovf && !lv_s2_r |=> status_r[rsq_pkg::ST_WDOG] && state_r == ST_STAB ##2 !o_rst_pin_oe_n;
  endproperty
  a_wdog_flag: assert property (p_wdog_flag) else $error("watchdog overflow did not reset");

  property p_wdog_clear;
    @(posedge i_clk) disable iff (!i_rst_n)
    wdog_clr |=> wdog_r == '0;
  endproperty
  a_wdog_clear: assert property (p_wdog_clear) else $error("watchdog not cleared by write");

  property p_lv_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
    lv_s2_r |=> state_r == ST_LVHOLD ##1 !o_rst_pin_oe_n;
  endproperty
  a_lv_hold: assert property (p_lv_hold) else $error("low voltage did not hold reset");

  property p_badop;
    @(posedge i_clk) disable iff (!i_rst_n)
    int_req && i_cpu_ev.bad_opcode && !lv_s2_r |=> status_r[rsq_pkg::ST_BADOP] ##2 !o_rst_pin_oe_n;
  endproperty
  a_badop: assert property (p_badop) else $error("bad opcode flag not set");

  property p_stop_clear;
    @(posedge i_clk) disable iff (!i_rst_n)
    state_r == ST_RUN && i_cpu_ev.stop_exec |=> cnt_r == '0 ##1 cnt_r == 12'h001;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stop did not clear counter");

  property p_short_wake;
    @(posedge i_clk) disable iff (!i_rst_n)
    state_r == ST_STOP && i_cpu_ev.wakeup && config_r[rsq_pkg::CFG_SHORT] && !lv_s2_r
      |=> (state_r == ST_WAKE) [*8] ##25 state_r == ST_RUN;
  endproperty
  a_short_wake: assert property (p_short_wake) else $error("short recovery not 32 cycles");
endmodule : rsq_reset_sequencer

// ### sim/rsq_far_side.sv
// far side model: reset pin with pull-up and an outside pull-down switch
module rsq_far_side (
  input wire logic i_pin_out,
  input wire logic i_pin_oe_n,
  input wire logic i_ext_low,
  output logic o_pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-up holds the pin high unless a party pulls low
  assign o_pin_level = !((!i_pin_oe_n && !i_pin_out) || i_ext_low);
endmodule : rsq_far_side

// ### sim/rsq_reset_sequencer_tb.sv
// self-checking bench for the reset sequencer
module rsq_reset_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst_n, i_low_voltage, i_wr, i_rd, ext_low, pin_level, rd_seen;
  rsq_pkg::rsq_cpu_ev_t i_cpu_ev;
  logic [7:0] i_vector_byte, i_wdata, o_rdata;
  logic [15:0] i_addr;
  logic o_rst_pin_out, o_rst_pin_oe_n, o_cpu_rst_n, o_clk_run, o_clk_gen_en, o_poweron_pulse;
  logic [7:0] exp_q[$];
  logic [31:0] rnd;
  int error_cnt, tests_run, cyc, tp, tc, tr;

  rsq_reset_sequencer i_rsq_reset_sequencer (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_low_voltage(i_low_voltage), .i_rst_pin_in(pin_level), .i_cpu_ev(i_cpu_ev),
    .i_vector_byte(i_vector_byte), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_rst_pin_out(o_rst_pin_out), .o_rst_pin_oe_n(o_rst_pin_oe_n),
    .o_cpu_rst_n(o_cpu_rst_n), .o_clk_run(o_clk_run), .o_clk_gen_en(o_clk_gen_en),
    .o_poweron_pulse(o_poweron_pulse));
  rsq_far_side i_rsq_far_side (.i_pin_out(o_rst_pin_out), .i_pin_oe_n(o_rst_pin_oe_n),
    .i_ext_low(ext_low), .o_pin_level(pin_level));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  function automatic logic [31:0] inr(input int v, input int lo, input int hi);
    return {31'h0, v >= lo && v <= hi};
  endfunction : inr

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask : wr

  task automatic ev(input logic [3:0] e);
    i_cpu_ev <= e;
    @(posedge i_clk);
    i_cpu_ev <= '0;
    @(posedge i_clk);
  endtask : ev

  // cycles until pin released, cpu released and clocks running
  task automatic seq_len();
    tp = 0;
    tc = 0;
    tr = 0;
    for (int k = 1; k < 5000 && (tc == 0 || tr == 0); k++)
    begin
      @(negedge i_clk);
      if (tp == 0 && o_rst_pin_oe_n === 1'b1) tp = k;
      if (tc == 0 && o_cpu_rst_n === 1'b1) tc = k;
      if (tr == 0 && o_clk_run === 1'b1) tr = k;
    end
    @(posedge i_clk);
  endtask : seq_len

  task automatic full_seq(input int lo, input int hi, input logic [7:0] st, input string s);
    seq_len();
    chk(inr(tp, lo, hi), 1);
    chk(tc - tp, 32);
    chk(tp - tr, 32);
    chk(o_clk_gen_en, 1);
    rd(rsq_pkg::STATUS_ADDR, st);
    $display("test done: %s", s);
  endtask : full_seq

  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  always @(posedge i_clk)
  begin
    rd_seen <= i_rd;
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      close_out();
    end
  end

  always @(negedge i_clk)
    if (rd_seen === 1'b1 && exp_q.size() > 0)
      chk(o_rdata, exp_q.pop_front());

  initial
  begin
    i_rst_n = 1'b0;
    i_low_voltage = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    ext_low = 1'b0;
    rd_seen = 1'b0;
    i_cpu_ev = '0;
    i_vector_byte = 8'hff;
    i_wdata = 8'h00;
    i_addr = 16'h0000;
    rnd = 32'd49;
    repeat (4) @(posedge i_clk);
    chk(o_rst_pin_oe_n, 0);
    chk(o_poweron_pulse, 1);
    i_rst_n <= 1'b1;
    full_seq(4126, 4134, rsq_pkg::STATUS_POR_VAL, "power-on");
    chk(o_poweron_pulse, 0);
    rnd = xs(rnd);
    wr(16'hffff, rnd[7:0]);
    rd(16'h1234, 8'h00);
    ev(4'b1000);
    full_seq(4120, 4136, 8'h10, "bad opcode");
    rnd = xs(rnd);
    i_vector_byte <= {1'b0, rnd[6:0]};
    ev(4'b0100);
    repeat (8) @(posedge i_clk);
    chk(o_cpu_rst_n, 1);
    i_vector_byte <= 8'hff;
    ev(4'b0100);
    full_seq(4120, 4136, 8'h08, "monitor entry");
    i_low_voltage <= 1'b1;
    repeat (40) @(posedge i_clk);
    chk(o_rst_pin_oe_n, 0);
    i_low_voltage <= 1'b0;
    full_seq(4126, 4145, 8'h02, "low voltage");
    ext_low <= 1'b1;
    repeat (4) @(posedge i_clk);
    ext_low <= 1'b0;
    seq_len();
    chk(inr(tc, 30, 42), 1);
    rd(rsq_pkg::STATUS_ADDR, 8'h40);
    wr(rsq_pkg::CONFIG_ADDR, 8'h01);
    rd(rsq_pkg::CONFIG_ADDR, 8'h01);
    ev(4'b0010);
    @(negedge i_clk);
    chk(o_clk_run, 0);
    @(posedge i_clk);
    ev(4'b0001);
    seq_len();
    chk(inr(tr, 28, 38), 1);
    wr(rsq_pkg::CONFIG_ADDR, 8'h00);
    ev(4'b0010);
    ev(4'b0001);
    seq_len();
    chk(inr(tr, 4092, 4104), 1);
    $display("test done: stop recovery");
    close_out();
  end
endmodule : rsq_reset_sequencer_tb
